/* File: design/apm_pin_mux.sv */
/*
 * Graphics-port pin multiplexer: the shared pins serve either the AGP core
 * or two digital video ports plus display serial lines, chosen by a strap
 * on the parity pin. Also drives the CRT sync outputs and holds a small
 * register file on an Avalon-MM slave.
 * Assumes the AGP core and the pixel sources run on clk; pins are asynchronous.
 */
`timescale 1ns/100ps
module apm_pin_mux (
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic        ce,
    // Avalon-MM slave.
    input  wire logic [19:0] avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    // Shared pins.
    input  wire logic [35:0] pin_ad_in,
    output logic      [35:0] pin_ad_out,
    output logic      [35:0] pin_ad_oe_n,
    input  wire logic [4:0]  pin_ctl_in,
    output logic      [4:0]  pin_ctl_out,
    output logic      [4:0]  pin_ctl_oe_n,
    input  wire logic [3:0]  pin_stb_in,
    output logic      [3:0]  pin_stb_out,
    output logic      [3:0]  pin_stb_oe_n,
    input  wire logic        pin_par_in,
    output logic             pin_par_out,
    output logic             pin_par_oe_n,
    input  wire logic [7:0]  pin_sba_in,
    // AGP core side.
    input  wire logic [35:0] agp_ad_out,
    input  wire logic [35:0] agp_ad_oe,
    output logic      [35:0] agp_ad_in,
    input  wire logic [4:0]  agp_ctl_out,
    input  wire logic [4:0]  agp_ctl_oe,
    output logic      [4:0]  agp_ctl_in,
    input  wire logic [3:0]  agp_stb_out,
    input  wire logic [3:0]  agp_stb_oe,
    output logic      [3:0]  agp_stb_in,
    input  wire logic        agp_par_out,
    input  wire logic        agp_par_oe,
    output logic             agp_par_in,
    output logic             agp_mode,
    // Video side.
    input  wire logic [23:0] port_b_pixel_bits,
    input  wire logic        port_b_valid,
    output logic             port_b_ready,
    input  wire logic        port_b_hsync,
    input  wire logic        port_b_vsync,
    input  wire logic        port_b_blank_n,
    input  wire logic [23:0] port_c_pixel_bits,
    input  wire logic        port_c_valid,
    output logic             port_c_ready,
    input  wire logic        port_c_hsync,
    input  wire logic        port_c_vsync,
    input  wire logic        port_c_blank_n,
    output logic             video_mode,
    output logic             video_clkint,
    output logic             video_intr_n,
    output logic             port_b_field_stall,
    output logic             port_c_field_stall,
    // Serial lines: mux clock, mux data, primary clock, primary data, secondary clock, secondary data.
    input  wire logic [5:0]  serial_drive_low,
    output logic      [5:0]  serial_level,
    // CRT sync.
    input  wire logic        crt_hsync_act,
    input  wire logic        crt_vsync_act,
    output logic             crt_hsync,
    output logic             crt_vsync
);
    localparam int SYNC_W = 36 + 5 + 4 + 1 + 8;

    apm_pkg::apm_mode_t mode_q;
    apm_pkg::apm_mode_t mode_d;
    logic [2:0]         settle_q;
    logic [7:0]         ident_q;
    logic               strap_q;
    logic [4:0]         ctrl_q;
    logic               ack_q;
    logic [31:0]        rdata_q;
    logic [SYNC_W-1:0]  sync1_q;
    logic [SYNC_W-1:0]  sync2_q;
    logic [35:0]        ad_out_q;
    logic [35:0]        ad_oe_n_q;
    logic [4:0]         ctl_out_q;
    logic [4:0]         ctl_oe_n_q;
    logic [3:0]         stb_out_q;
    logic [3:0]         stb_oe_n_q;
    logic               par_out_q;
    logic               par_oe_n_q;
    logic               hs_q;
    logic               vs_q;

    logic [35:0]        s_ad;
    logic [4:0]         s_ctl;
    logic [3:0]         s_stb;
    logic               s_par;
    logic [7:0]         s_sba;
    logic               is_agp;
    logic               is_video;
    logic               bus_req;
    logic               bus_take;
    logic               hit_ctrl;
    logic               hit_status;
    logic               hit_id;
    logic               ctrl_wr;
    logic [31:0]        rd_w;
    logic [35:0]        vid_ad;
    logic [35:0]        vid_oe;
    logic [35:0]        ad_out_d;
    logic [35:0]        ad_oe_n_d;
    logic [4:0]         ctl_out_d;
    logic [4:0]         ctl_oe_n_d;
    logic [3:0]         stb_out_d;
    logic [3:0]         stb_oe_n_d;
    logic               par_out_d;
    logic               par_oe_n_d;
    logic               hs_d;
    logic               vs_d;
    logic               h_act;

    apm_pix_if pix_b ();
    apm_pix_if pix_c ();

    apm_pix_port u_port_b (
        .clk    (clk),
        .resetn (resetn),
        .ce     (ce),
        .pif    (pix_b.port)
    );

    apm_pix_port u_port_c (
        .clk    (clk),
        .resetn (resetn),
        .ce     (ce),
        .pif    (pix_c.port)
    );

    // Every pin input crosses two flops before anything reads it.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else if (ce) begin
            sync1_q <= {pin_sba_in, pin_par_in, pin_stb_in, pin_ctl_in, pin_ad_in};
            sync2_q <= sync1_q;
        end
    end

    assign s_ad  = sync2_q[35:0];
    assign s_ctl = sync2_q[40:36];
    assign s_stb = sync2_q[44:41];
    assign s_par = sync2_q[45];
    assign s_sba = sync2_q[53:46];

    // The strap is read once after release, when the chain holds fresh pin levels.
    always_comb begin
        mode_d = mode_q;
        case (mode_q)
            apm_pkg::APM_MODE_SAMPLING: begin
                if (settle_q == apm_pkg::APM_STRAP_SETTLE) begin
                    mode_d = (s_par == apm_pkg::APM_STRAP_VIDEO) ? apm_pkg::APM_MODE_VIDEO
                                                                  : apm_pkg::APM_MODE_AGP;
                end
            end
            apm_pkg::APM_MODE_AGP:   mode_d = apm_pkg::APM_MODE_AGP;
            apm_pkg::APM_MODE_VIDEO: mode_d = apm_pkg::APM_MODE_VIDEO;
            default:                 mode_d = apm_pkg::APM_MODE_SAMPLING;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            mode_q   <= apm_pkg::APM_MODE_SAMPLING;
            settle_q <= 3'h0;
            ident_q  <= 8'h00;
            strap_q  <= 1'b1;
        end else if (ce) begin
            mode_q <= mode_d;
            if (mode_q == apm_pkg::APM_MODE_SAMPLING) begin
                settle_q <= settle_q + 3'h1;
                if (settle_q == apm_pkg::APM_STRAP_SETTLE) begin
                    ident_q <= s_sba;
                    strap_q <= s_par;
                end
            end
        end
    end

    assign is_agp   = (mode_q == apm_pkg::APM_MODE_AGP);
    assign is_video = (mode_q == apm_pkg::APM_MODE_VIDEO);

    // Register bus: every request is answered one cycle after it appears.
    assign bus_req    = avs_read | avs_write;
    assign bus_take   = bus_req & ~ack_q;
    assign hit_ctrl   = (avs_address == apm_pkg::APM_CTRL_OFS);
    assign hit_status = (avs_address == apm_pkg::APM_STATUS_OFS);
    assign hit_id     = (avs_address == apm_pkg::APM_ID_OFS);
    assign ctrl_wr    = ack_q & avs_write & hit_ctrl & avs_byteenable[0];

    always_comb begin
        if (hit_ctrl) begin
            rd_w = {27'h0, ctrl_q};
        end else if (hit_status) begin
            rd_w = {29'h0, strap_q, is_video, is_agp | is_video};
        end else if (hit_id) begin
            rd_w = {24'h0, is_video ? ident_q : 8'h00};
        end else begin
            rd_w = 32'h0;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            ack_q   <= 1'b0;
            rdata_q <= 32'h0;
            ctrl_q  <= apm_pkg::APM_CTRL_RESET;
        end else if (ce) begin
            ack_q <= bus_take;
            if (bus_take & avs_read) begin
                rdata_q <= rd_w;
            end
            if (ctrl_wr) begin
                ctrl_q <= avs_writedata[4:0];
            end
        end
    end

    assign avs_waitrequest = ~ack_q;
    assign avs_readdata    = rdata_q;

    assign pix_b.word    = port_b_pixel_bits;
    assign pix_b.valid   = port_b_valid;
    assign pix_b.enable  = is_video & ctrl_q[apm_pkg::APM_CTRL_B_EN];
    assign pix_b.hsync   = port_b_hsync;
    assign pix_b.vsync   = port_b_vsync;
    assign pix_b.blank_n = port_b_blank_n;
    assign pix_c.word    = port_c_pixel_bits;
    assign pix_c.valid   = port_c_valid;
    assign pix_c.enable  = is_video & ctrl_q[apm_pkg::APM_CTRL_C_EN];
    assign pix_c.hsync   = port_c_hsync;
    assign pix_c.vsync   = port_c_vsync;
    assign pix_c.blank_n = port_c_blank_n;
    assign port_b_ready  = pix_b.ready;
    assign port_c_ready  = pix_c.ready;

    // Video pin image: the two ports land on their fixed pin positions.
    always_comb begin
        vid_ad = 36'h0_0000_0000;
        for (int i = 0; i < apm_pkg::APM_PIX_W; i++) begin
            vid_ad[apm_pkg::APM_B_MAP[i]] = pix_b.d[i];
            vid_ad[apm_pkg::APM_C_MAP[i]] = pix_c.d[i];
        end
        vid_ad[apm_pkg::APM_B_HS] = pix_b.hs_o;
        vid_ad[apm_pkg::APM_B_VS] = pix_b.vs_o;
        vid_ad[apm_pkg::APM_B_BL] = pix_b.bl_o;
        vid_ad[apm_pkg::APM_C_HS] = pix_c.hs_o;
        vid_ad[apm_pkg::APM_C_VS] = pix_c.vs_o;
        vid_ad[apm_pkg::APM_C_BL] = pix_c.bl_o;
        vid_oe = apm_pkg::APM_VID_DRIVE;
        vid_oe[apm_pkg::APM_SEC_DATA] = serial_drive_low[5];
    end

    // Strobe pins are {port C clock#, port B clock#, port C clock, port B clock}.
    always_comb begin
        ad_out_d   = 36'h0_0000_0000;
        ad_oe_n_d  = 36'hF_FFFF_FFFF;
        ctl_out_d  = 5'h00;
        ctl_oe_n_d = 5'h1F;
        stb_out_d  = 4'h0;
        stb_oe_n_d = 4'hF;
        par_out_d  = 1'b0;
        par_oe_n_d = 1'b1;
        if (is_agp) begin
            ad_out_d   = agp_ad_out;
            ad_oe_n_d  = ~agp_ad_oe;
            ctl_out_d  = agp_ctl_out;
            ctl_oe_n_d = ~agp_ctl_oe;
            stb_out_d  = agp_stb_out;
            stb_oe_n_d = ~agp_stb_oe;
            par_out_d  = agp_par_out;
            par_oe_n_d = ~agp_par_oe;
        end else if (is_video) begin
            ad_out_d   = vid_ad;
            ad_oe_n_d  = ~vid_oe;
            ctl_oe_n_d = ~serial_drive_low[4:0];
            stb_out_d  = {pix_c.clk_n, pix_b.clk_n, pix_c.clk_p, pix_b.clk_p};
            stb_oe_n_d = 4'h0;
        end
    end

    // Sync interval is the union of both blanking syncs when APM_CTRL_HINTVL is set, else the hsync alone.
    assign h_act = ctrl_q[apm_pkg::APM_CTRL_HINTVL] ? (crt_hsync_act | crt_vsync_act) : crt_hsync_act;
    assign hs_d  = ctrl_q[apm_pkg::APM_CTRL_HPOL] ? h_act : ~h_act;
    assign vs_d  = ctrl_q[apm_pkg::APM_CTRL_VPOL] ? crt_vsync_act : ~crt_vsync_act;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            ad_out_q   <= 36'h0_0000_0000;
            ad_oe_n_q  <= 36'hF_FFFF_FFFF;
            ctl_out_q  <= 5'h00;
            ctl_oe_n_q <= 5'h1F;
            stb_out_q  <= 4'h0;
            stb_oe_n_q <= 4'hF;
            par_out_q  <= 1'b0;
            par_oe_n_q <= 1'b1;
            hs_q       <= 1'b0;
            vs_q       <= 1'b0;
        end else if (ce) begin
            ad_out_q   <= ad_out_d;
            ad_oe_n_q  <= ad_oe_n_d;
            ctl_out_q  <= ctl_out_d;
            ctl_oe_n_q <= ctl_oe_n_d;
            stb_out_q  <= stb_out_d;
            stb_oe_n_q <= stb_oe_n_d;
            par_out_q  <= par_out_d;
            par_oe_n_q <= par_oe_n_d;
            hs_q       <= hs_d;
            vs_q       <= vs_d;
        end
    end

    // Reset also floats the pins at once, before the first clock edge arrives.
    assign pin_ad_out   = ad_out_q;
    assign pin_ad_oe_n  = ad_oe_n_q | {36{~resetn}};
    assign pin_ctl_out  = ctl_out_q;
    assign pin_ctl_oe_n = ctl_oe_n_q | {5{~resetn}};
    assign pin_stb_out  = stb_out_q;
    assign pin_stb_oe_n = stb_oe_n_q | {4{~resetn}};
    assign pin_par_out  = par_out_q;
    assign pin_par_oe_n = par_oe_n_q | ~resetn;

    assign agp_ad_in          = s_ad;
    assign agp_ctl_in         = s_ctl;
    assign agp_stb_in         = s_stb;
    assign agp_par_in         = s_par;
    assign agp_mode           = is_agp;
    assign video_mode         = is_video;
    assign video_clkint       = s_ad[apm_pkg::APM_IN_CLKINT];
    assign video_intr_n       = s_ad[apm_pkg::APM_IN_INTR];
    assign port_b_field_stall = s_ad[apm_pkg::APM_IN_B_FLD];
    assign port_c_field_stall = s_ad[apm_pkg::APM_IN_C_FLD];
    assign serial_level       = {s_ad[apm_pkg::APM_SEC_DATA], s_ctl};
    assign crt_hsync          = hs_q;
    assign crt_vsync          = vs_q;

endmodule : apm_pin_mux

/* File: design/apm_pkg.sv */
/*
 * Shared constants and types for the graphics-port pin multiplexer.
 * Assumes a single 20 MHz clock domain and byte addresses on the register bus.
 */
package apm_pkg;

    // Register map, byte addresses.
    localparam logic [19:0] APM_CTRL_OFS   = 20'h71400;
    localparam logic [19:0] APM_STATUS_OFS = 20'h71404;
    localparam logic [19:0] APM_ID_OFS     = 20'h71408;

    // Control register fields.
    localparam int          APM_CTRL_W       = 5;
    localparam int          APM_CTRL_HPOL    = 0;
    localparam int          APM_CTRL_VPOL    = 1;
    localparam int          APM_CTRL_HINTVL  = 2;
    localparam int          APM_CTRL_B_EN    = 3;
    localparam int          APM_CTRL_C_EN    = 4;
    localparam logic [4:0]  APM_CTRL_RESET   = 5'h03;

    // Strap handling.
    localparam logic        APM_STRAP_VIDEO  = 1'b0;
    localparam logic [2:0]  APM_STRAP_SETTLE = 3'h4;
    localparam int          APM_ID_W         = 8;

    // Shared pin vector: address/data pins 0..31, command/byte-enable pins 32..35.
    localparam int          APM_PIN_W        = 36;
    localparam int          APM_CTL_W        = 5;
    localparam int          APM_STB_W        = 4;
    localparam int          APM_SER_W        = 6;
    localparam int          APM_PIX_W        = 12;
    localparam int          APM_B_MAP [12]   = '{3, 2, 5, 4, 7, 6, 8, 32, 10, 9, 12, 11};
    localparam int          APM_C_MAP [12]   = '{19, 20, 21, 22, 23, 35, 25, 24, 27, 26, 29, 28};
    localparam int          APM_B_HS         = 0;
    localparam int          APM_B_VS         = 1;
    localparam int          APM_B_BL         = 33;
    localparam int          APM_C_HS         = 17;
    localparam int          APM_C_VS         = 16;
    localparam int          APM_C_BL         = 18;
    localparam int          APM_IN_CLKINT    = 13;
    localparam int          APM_IN_B_FLD     = 14;
    localparam int          APM_SEC_DATA     = 15;
    localparam int          APM_IN_INTR      = 30;
    localparam int          APM_IN_C_FLD     = 31;
    localparam logic [35:0] APM_VID_DRIVE    = 36'hB_3FFF_1FFF;

    typedef enum logic [1:0] {
        APM_MODE_SAMPLING = 2'b00,
        APM_MODE_AGP      = 2'b01,
        APM_MODE_VIDEO    = 2'b10
    } apm_mode_t;

    typedef enum logic [0:0] {
        APM_PH_LOW  = 1'b0,
        APM_PH_HIGH = 1'b1
    } apm_phase_t;

endpackage : apm_pkg

/* File: design/apm_pix_if.sv */
/*
 * Carrier between the pin multiplexer and one pixel port serializer.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/100ps
interface apm_pix_if;
    logic [23:0] word;
    logic        valid;
    logic        ready;
    logic        enable;
    logic        hsync;
    logic        vsync;
    logic        blank_n;
    logic [11:0] d;
    logic        clk_p;
    logic        clk_n;
    logic        hs_o;
    logic        vs_o;
    logic        bl_o;

    modport src  (output word, valid, enable, hsync, vsync, blank_n,
                  input  ready, d, clk_p, clk_n, hs_o, vs_o, bl_o);
    modport port (input  word, valid, enable, hsync, vsync, blank_n,
                  output ready, d, clk_p, clk_n, hs_o, vs_o, bl_o);
endinterface : apm_pix_if

/* File: design/apm_pix_port.sv */
/*
 * Serializer for one digital video port: a 24-bit pixel leaves as two
 * 12-bit halves, one on each level of the generated pixel clock.
 * Assumes the pixel clock out runs at half the block clock.
 */
`timescale 1ns/100ps
module apm_pix_port (
    input  wire logic  clk,
    input  wire logic  resetn,
    input  wire logic  ce,
    apm_pix_if.port    pif
);
    apm_pkg::apm_phase_t phase_q;
    logic [11:0]         hi_q;
    logic [11:0]         d_q;
    logic                clk_q;
    logic                hs_q;
    logic                vs_q;
    logic                bl_q;
    logic                take_w;

    assign pif.ready = pif.enable & (phase_q == apm_pkg::APM_PH_LOW);
    assign take_w    = pif.ready & pif.valid;

    // Low half rides the high clock level, high half the low level, so
    // every clock edge carries a new half-word.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            phase_q <= apm_pkg::APM_PH_LOW;
            hi_q    <= 12'h000;
            d_q     <= 12'h000;
            clk_q   <= 1'b0;
            hs_q    <= 1'b0;
            vs_q    <= 1'b0;
            bl_q    <= 1'b0;
        end else if (ce) begin
            case (phase_q)
                apm_pkg::APM_PH_LOW: begin
                    if (pif.enable) begin
                        d_q     <= take_w ? pif.word[11:0] : 12'h000;
                        hi_q    <= take_w ? pif.word[23:12] : 12'h000;
                        hs_q    <= pif.hsync;
                        vs_q    <= pif.vsync;
                        bl_q    <= take_w & pif.blank_n;
                        clk_q   <= 1'b1;
                        phase_q <= apm_pkg::APM_PH_HIGH;
                    end else begin
                        d_q   <= 12'h000;
                        clk_q <= 1'b0;
                        bl_q  <= 1'b0;
                    end
                end
                apm_pkg::APM_PH_HIGH: begin
                    d_q     <= hi_q;
                    clk_q   <= 1'b0;
                    phase_q <= apm_pkg::APM_PH_LOW;
                end
                default: phase_q <= apm_pkg::APM_PH_LOW;
            endcase
        end
    end

    assign pif.d     = d_q;
    assign pif.clk_p = clk_q;
    assign pif.clk_n = ~clk_q;
    assign pif.hs_o  = hs_q;
    assign pif.vs_o  = vs_q;
    assign pif.bl_o  = bl_q;

endmodule : apm_pix_port

/* File: tb/apm_pin_mux_monitor.sv */
/* Concurrent checks on the pin multiplexer ports.
   Assumes one clock domain; a shadow of the control register follows bus writes. */
`timescale 1ns/100ps
module apm_pin_mux_monitor (
    input wire logic        clk, resetn, ce, avs_read, avs_write, avs_waitrequest,
    input wire logic [19:0] avs_address,
    input wire logic [31:0] avs_writedata, avs_readdata,
    input wire logic [3:0]  avs_byteenable, pin_stb_out, pin_stb_oe_n,
    input wire logic [35:0] pin_ad_out, pin_ad_oe_n, agp_ad_out, agp_ad_oe, pin_ad_in, agp_ad_in,
    input wire logic [4:0]  pin_ctl_oe_n,
    input wire logic [7:0]  pin_sba_in,
    input wire logic        pin_par_in, pin_par_oe_n, agp_mode, video_mode,
    input wire logic        crt_hsync_act, crt_vsync_act, crt_hsync, crt_vsync
);
    logic [4:0] ctl_q;
    wire ctl_we = ce && avs_write && !avs_waitrequest && avs_byteenable[0] && avs_address == apm_pkg::APM_CTRL_OFS;
    wire hs_src = crt_hsync_act | (ctl_q[2] & crt_vsync_act);
    always_ff @(posedge clk) begin
        if (!resetn) ctl_q <= apm_pkg::APM_CTRL_RESET;
        else if (ctl_we) ctl_q <= avs_writedata[4:0];
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    a_reset_float: assert property (disable iff (1'b0) !resetn |-> &pin_ctl_oe_n && pin_ad_oe_n[15])
        else $error("serial line driven during reset");
    a_strap_mode: assert property ($rose(agp_mode | video_mode) |-> agp_mode == pin_par_in && video_mode != agp_mode)
        else $error("mode does not follow strap");
    a_parity_free: assert property (video_mode |-> pin_par_oe_n)
        else $error("parity pin driven in video mode");
    a_id_read: assert property (avs_read && !avs_waitrequest && avs_address == apm_pkg::APM_ID_OFS
        |-> avs_readdata == (video_mode ? {24'h0, pin_sba_in} : 32'h0)) else $error("identity read wrong");
    a_pix_pair: assert property (video_mode && !pin_stb_oe_n[0] |-> pin_stb_out[2] != pin_stb_out[0])
        else $error("port clock pair not complementary");
    a_pix_toggle: assert property ($past(video_mode, 2) && $past(ctl_q[4], 2) && $past(ce) && $past(ce, 2)
        |-> pin_stb_out[1] != $past(pin_stb_out[1])) else $error("port clock did not toggle");
    a_agp_follow: assert property (agp_mode && $past(agp_mode) && $past(ce) |-> pin_ad_oe_n == ~$past(agp_ad_oe)
        && (pin_ad_out | pin_ad_oe_n) == ($past(agp_ad_out) | ~$past(agp_ad_oe))) else $error("pins left core");
    a_hsync_pol: assert property ($past(resetn) && $past(ce) |-> crt_hsync == ($past(hs_src) ~^ $past(ctl_q[0])))
        else $error("hsync polarity wrong");
    a_vsync_pol: assert property ($past(resetn) && $past(ce) |-> crt_vsync == ($past(crt_vsync_act) ~^ $past(ctl_q[1])))
        else $error("vsync polarity wrong");
    a_bus_answer: assert property ((avs_read || avs_write) && avs_waitrequest && ce |=> !avs_waitrequest ##1 avs_waitrequest)
        else $error("bus answer not one cycle");
    a_pin_sync: assert property ($past(resetn) && $past(resetn, 2) && $past(ce) && $past(ce, 2)
        |-> agp_ad_in == $past(pin_ad_in, 2)) else $error("pin levels not passed to core");
endmodule : apm_pin_mux_monitor
bind apm_pin_mux apm_pin_mux_monitor u_apm_pin_mux_monitor (.*);

/* File: tb/apm_card_model.sv */
/* Add-in card side of the shared pins: straps, pull-ups and idle lines.
   Assumes serial lines and GAD15 carry pull-ups on the card. */
`timescale 1ns/100ps
module apm_card_model (
    input  wire logic        clk, strap, pin_par_out, pin_par_oe_n,
    input  wire logic [7:0]  card_id,
    input  wire logic [35:0] pin_ad_out, pin_ad_oe_n,
    input  wire logic [4:0]  pin_ctl_out, pin_ctl_oe_n,
    input  wire logic [3:0]  pin_stb_out, pin_stb_oe_n,
    output logic      [35:0] pin_ad_in,
    output logic      [4:0]  pin_ctl_in,
    output logic      [3:0]  pin_stb_in,
    output logic             pin_par_in,
    output logic      [7:0]  pin_sba_in
);
    // Released AD and strobe lines other than GAD15 flip every cycle, so a stale value never passes for a driven one.
    logic [35:0] idle_q = 36'h5_A5A5_A5A5;
    always_ff @(posedge clk) idle_q <= ~idle_q;
    assign pin_sba_in = card_id;
    assign pin_par_in = pin_par_oe_n ? strap : pin_par_out;
    assign pin_ctl_in = pin_ctl_out | pin_ctl_oe_n;
    assign pin_ad_in  = (pin_ad_out & ~pin_ad_oe_n) | ({idle_q[35:16], 1'b1, idle_q[14:0]} & pin_ad_oe_n);
    assign pin_stb_in = (pin_stb_out & ~pin_stb_oe_n) | (idle_q[3:0] & pin_stb_oe_n);
endmodule : apm_card_model

/* File: tb/tb_top.sv */
/* Self-checking bench for the pin multiplexer: video mode, then AGP mode.
   Assumes the card model closes the shared pins and the monitor is bound. */
`timescale 1ns/100ps
module tb_top;
    logic        clk, resetn = 0, ce = 1, avs_read = 0, avs_write = 0, strap = 0, avs_waitrequest, agp_mode;
    logic [19:0] avs_address = '0;
    logic [31:0] avs_writedata = '0, avs_readdata;
    logic [3:0]  avs_byteenable = 4'hF, pin_stb_in, pin_stb_out, pin_stb_oe_n, agp_stb_out = '0, agp_stb_oe = '0;
    logic [3:0]  agp_stb_in;
    logic        pin_par_in, pin_par_out, pin_par_oe_n, agp_par_out = 0, agp_par_oe = 0, agp_par_in;
    logic [35:0] pin_ad_in, pin_ad_out, pin_ad_oe_n, agp_ad_out = '0, agp_ad_oe = '0, agp_ad_in;
    logic [4:0]  pin_ctl_in, pin_ctl_out, pin_ctl_oe_n, agp_ctl_out = '0, agp_ctl_oe = '0, agp_ctl_in;
    logic [7:0]  pin_sba_in, card_id = '0;
    logic [23:0] port_b_pixel_bits = '0, port_c_pixel_bits = '0;
    logic        port_b_valid = 0, port_c_valid = 0, port_b_ready, port_c_ready, port_b_hsync = 0, port_b_vsync = 0;
    logic        port_b_blank_n = 0, port_c_hsync = 0, port_c_vsync = 0, port_c_blank_n = 0, video_mode, video_clkint;
    logic        video_intr_n, port_b_field_stall, port_c_field_stall, crt_hsync_act = 0, crt_vsync_act = 0;
    logic        crt_hsync, crt_vsync;
    logic [5:0]  serial_drive_low = '0, serial_level;
    int          n_errors = 0, n_compared = 0, cyc = 0;
    int          bm[12] = '{3, 2, 5, 4, 7, 6, 8, 32, 10, 9, 12, 11};
    int          cm[12] = '{19, 20, 21, 22, 23, 35, 25, 24, 27, 26, 29, 28};

    apm_pin_mux u_apm_pin_mux (.*);
    apm_card_model u_apm_card_model (.*);

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic results;
        $display("compared %0d, mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : results

    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        n_compared++;
        if (s !== e) begin
            n_errors++;
            $display("[FAIL] %0t: seen %h expected %h", $time, s, e);
        end
    endtask : chk

    // Holds the request until waitrequest is seen low at a rising edge.
    task automatic bus(input logic w, input logic [19:0] a, input logic [31:0] d, output logic [31:0] q);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge clk);
    endtask : bus

    function automatic logic [11:0] pick(input logic [35:0] p, input bit c);
        for (int i = 0; i < 12; i++) pick[i] = p[c ? cm[i] : bm[i]];
    endfunction : pick

    always @(posedge clk) begin
        agp_ad_out <= 36'({$urandom, $urandom});
        agp_ad_oe <= 36'({$urandom, $urandom});
        {agp_ctl_out, agp_ctl_oe, agp_stb_out, agp_stb_oe, agp_par_out, agp_par_oe} <= 20'($urandom);
        {crt_hsync_act, crt_vsync_act, port_b_hsync, port_b_vsync} <= 4'($urandom);
        {port_b_blank_n, port_c_hsync, port_c_vsync, port_c_blank_n} <= 4'($urandom);
        cyc++;
        if (cyc == 3000) begin
            n_errors++;
            results();
        end
    end

    initial begin
        logic [31:0] q;
        logic [23:0] wb, wc;
        void'($urandom(32'hD14E37AA));
        card_id = 8'($urandom);
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        repeat (10) @(posedge clk);
        chk(32'(video_mode), 32'h1);
        bus(1'b1, apm_pkg::APM_ID_OFS, 32'hFFFF_FFFF, q);
        bus(1'b0, apm_pkg::APM_ID_OFS, 32'h0, q);
        chk(q, {24'h0, card_id});
        bus(1'b0, apm_pkg::APM_STATUS_OFS, 32'h0, q);
        chk(q, 32'h3);
        bus(1'b0, 20'h7140C, 32'h0, q);
        chk(q, 32'h0);
        bus(1'b0, apm_pkg::APM_CTRL_OFS, 32'h0, q);
        chk(q, 32'h3);
        for (int i = 0; i < 8; i++) begin
            bus(1'b1, apm_pkg::APM_CTRL_OFS, {27'($urandom), 2'b11, 3'(i)}, q);
            bus(1'b0, apm_pkg::APM_CTRL_OFS, 32'h0, q);
            chk(q, {27'h0, 2'b11, 3'(i)});
            ce <= i[0];
            repeat (24) @(posedge clk);
            ce <= 1'b1;
        end
        avs_byteenable <= 4'hE;
        bus(1'b1, apm_pkg::APM_CTRL_OFS, 32'h0, q);
        avs_byteenable <= 4'hF;
        bus(1'b0, apm_pkg::APM_CTRL_OFS, 32'h0, q);
        chk(q, 32'h1F);
        wb = 24'($urandom);
        wc = 24'($urandom);
        {port_b_pixel_bits, port_c_pixel_bits, port_b_valid, port_c_valid} <= {wb, wc, 2'b11};
        repeat (8) @(posedge clk);
        for (int k = 0; k < 8; k++) begin
            @(negedge clk);
            chk(32'(pick(pin_ad_out, 0)), 32'(pin_stb_out[0] ? wb[11:0] : wb[23:12]));
            chk(32'(pick(pin_ad_out, 1)), 32'(pin_stb_out[1] ? wc[11:0] : wc[23:12]));
            chk(32'(pin_stb_oe_n), 32'h0);
        end
        @(posedge clk);
        serial_drive_low <= 6'h2A;
        repeat (5) @(posedge clk);
        chk({26'h0, serial_level}, 32'h15);
        {strap, resetn, serial_drive_low} <= {2'b10, 6'h3F};
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        repeat (10) @(posedge clk);
        chk(32'(agp_mode), 32'h1);
        bus(1'b0, apm_pkg::APM_ID_OFS, 32'h0, q);
        chk(q, 32'h0);
        bus(1'b0, apm_pkg::APM_STATUS_OFS, 32'h0, q);
        chk(q, 32'h5);
        repeat (40) @(posedge clk);
        results();
    end
endmodule : tb_top
